// ---- hw/rncs_map.vh ----
// register map, field positions, reset values and timing counts
// assumes: included by the rncs design files, 40 MHz ref_clk
`ifndef RNCS_MAP_VH
`define RNCS_MAP_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define RNCS_CLK_NS        25
`define RNCS_SEC_NS        1000000000
`define RNCS_SEC_CYC       (`RNCS_SEC_NS / `RNCS_CLK_NS)
`define RNCS_IDLE_SEC      30

// ----------------------------------------
// limits
// ----------------------------------------
`define RNCS_ADDR_MIN      12'h001
`define RNCS_ADDR_MAX      12'hffe
`define RNCS_SW_ADDR_MAX   12'hf9f
`define RNCS_NET_MAX       15'h7fff
`define RNCS_MIN_CHAN      7'h19
`define RNCS_NBR_CNT       4

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define RNCS_OFS_CTRL      8'h00
`define RNCS_OFS_NODE      8'h04
`define RNCS_OFS_NET       8'h08
`define RNCS_OFS_BEACON    8'h0c
`define RNCS_OFS_LCHK      8'h10
`define RNCS_OFS_LCHK_EFF  8'h14
`define RNCS_OFS_HUB       8'h18
`define RNCS_OFS_STAT      8'h1c
`define RNCS_OFS_RXL       8'h20
`define RNCS_OFS_MAP_LO    8'h24
`define RNCS_OFS_MAP_HI    8'h28
`define RNCS_OFS_MASK_LO   8'h2c
`define RNCS_OFS_MASK_HI   8'h30
`define RNCS_OFS_ACT_LO    8'h34
`define RNCS_OFS_ACT_HI    8'h38
`define RNCS_OFS_NBR0      8'h40

// ----------------------------------------
// control fields
// ----------------------------------------
`define RNCS_CTRL_ROUTED   0
`define RNCS_CTRL_IDLE_SD  1
`define RNCS_CTRL_PAR_LO   2
`define RNCS_CTRL_STOP     4
`define RNCS_CTRL_LEN_LO   5
`define RNCS_NBR_VALID     31

// ----------------------------------------
// reset values
// ----------------------------------------
`define RNCS_RST_CTRL      7'h00
`define RNCS_RST_NODE      12'h001
`define RNCS_RST_MASK      64'hffffffff_fff7ffff
`define RNCS_RST_MAP       64'hffffffff_ffffffff

`endif

// ---- hw/rncs_sec_tick.v ----
// one-cycle pulse every second of ref_clk
// assumes: clock at the rate in rncs_map.vh; reset may be pulsed to realign the phase
`timescale 1ns/1ps
`include "rncs_map.vh"

module rncs_sec_tick #(
   parameter SEC_CYCLES = `RNCS_SEC_CYC
) (
   input  wire ref_clk,
   input  wire reset,
   output reg  sec_tick_ff
);

   reg  [25:0] cnt_ff;
   wire        wrap;

   assign wrap = (cnt_ff == SEC_CYCLES[25:0] - 26'h0000001);

   always @(posedge ref_clk) begin
      if (reset) begin
         cnt_ff      <= 26'h0000000;
         sec_tick_ff <= 1'b0;
      end else begin
         cnt_ff      <= wrap ? 26'h0000000 : cnt_ff + 26'h0000001;
         sec_tick_ff <= wrap;
      end
   end

endmodule

// ---- hw/rncs_chan_sel.v ----
// picks the lowest eligible channels as the active set
// assumes: map and mask are quasi-static configuration
`timescale 1ns/1ps
`include "rncs_map.vh"

module rncs_chan_sel (
   input  wire        ref_clk,
   input  wire        reset,
   input  wire [63:0] chan_map,
   input  wire [63:0] chan_mask,
   output reg  [63:0] active_ff,
   output reg  [6:0]  elig_cnt_ff,
   output reg         cfg_err_ff
);

   wire [63:0] elig;
   wire [6:0]  cnt [0:64];
   wire [63:0] nxt_active;

   assign cnt[0] = 7'h00;

   genvar i;
   generate
      for (i = 0; i < 64; i = i + 1) begin : g_ch
         assign elig[i]       = chan_mask[i] & chan_map[i];
         assign cnt[i+1]      = cnt[i] + {6'h00, elig[i]};
         // lowest frequencies first, the rest dropped
         assign nxt_active[i] = elig[i] & (cnt[i] < `RNCS_MIN_CHAN);
      end
   endgenerate

   always @(posedge ref_clk) begin
      if (reset) begin
         active_ff   <= 64'h0000000000000000;
         elig_cnt_ff <= 7'h00;
         cfg_err_ff  <= 1'b1;
      end else begin
         active_ff   <= nxt_active;
         elig_cnt_ff <= cnt[64];
         cfg_err_ff  <= (cnt[64] < `RNCS_MIN_CHAN);
      end
   end

endmodule

// ---- hw/rncs_top.v ----
// configuration and channel-set control of a hopping radio node
// assumes: classic wishbone master on ref_clk, sync active-high reset,
// modem and serial engines act on the request pulses and levels below
//
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "rncs_map.vh"

// Operation
// - node address writes outside 1..4094 are ignored; address must be unique
// - beacon every period seconds, radio when routed, else serial port
// - beacon period zero sends no beacons
// - link-check period zero means 2.5 times beacon period, used and reported
// - link-check period in seconds is advertised in hello messages
// - no neighbour traffic for a link-check period starts a hello exchange
// - valid hub address makes node a branch forwarding unrouted packets to hub
// - with a hub, no neighbour list exchange beyond that hub
// - repeater accepts neighbours only inside configured inclusive ranges
// - empty range list, the reset default, accepts every neighbour
// - addresses above 3999 are never rejected by the range filter
// - read-only regional map, bit n one channel, 400 kHz steps from 902.4
// - at least 25 eligible channels needed to communicate
// - more than 25 eligible: the 25 lowest are the active set
// - enable mask resets with channel 19 cleared
// - read-only level and source address of the last received packet
// - idle shutdown powers serial transmitter down after 30 s quiet
// - serial parity, stop bits and character length are selectable
// - network number 0..32767, same in every radio of a network
module rncs_top #(
   parameter        SEC_CYCLES = `RNCS_SEC_CYC,
   parameter [63:0] REGION_MAP = `RNCS_RST_MAP
) (
   input  wire        ref_clk,
   input  wire        reset,
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [7:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   input  wire        rx_pkt_valid,
   input  wire [7:0]  rx_signal_level,
   input  wire [11:0] rx_src_addr,
   input  wire        nbr_traffic,
   input  wire        no_route,
   input  wire        peer_beyond_hub,
   input  wire [11:0] cand_addr,
   input  wire        serial_activity,
   output wire        cand_accept,
   output wire        nbr_list_ok,
   output reg         fwd_to_hub_ff,
   output reg         beacon_radio_ff,
   output reg         beacon_serial_ff,
   output reg         hello_radio_ff,
   output reg         hello_serial_ff,
   output wire [17:0] hello_link_period,
   output wire [11:0] node_address,
   output wire [14:0] network_number,
   output wire [11:0] hub_address,
   output wire        branch_router,
   output wire [63:0] active_chan,
   output wire        tx_enable,
   output reg         serial_tx_on_ff,
   output wire [1:0]  serial_parity,
   output wire        serial_two_stop,
   output wire [1:0]  serial_char_len
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   reg  [6:0]  ctrl_ff;
   reg  [11:0] node_ff;
   reg  [14:0] net_ff;
   reg  [15:0] beacon_ff;
   reg  [15:0] lchk_ff;
   reg  [11:0] hub_ff;
   reg  [63:0] mask_ff;
   reg  [7:0]  rxl_ff;
   reg  [11:0] rxl_src_ff;
   reg  [31:0] nbr_ff [0:`RNCS_NBR_CNT-1];
   reg  [15:0] bcn_cnt_ff;
   reg  [17:0] lnk_cnt_ff;
   reg  [4:0]  idle_cnt_ff;
   reg  [31:0] nxt_dat;
   reg  [31:0] wval;
   wire        req;
   wire        wr;
   wire        sec_tick;
   wire [63:0] act;
   wire [6:0]  elig_cnt;
   wire        cfg_err;
   wire [17:0] lnk_eff;
   wire        routed;
   wire [`RNCS_NBR_CNT-1:0] nbr_hit;
   wire [`RNCS_NBR_CNT-1:0] nbr_used;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   rncs_sec_tick #(
      .SEC_CYCLES (SEC_CYCLES)
   ) u_tick (
      .ref_clk     (ref_clk),
      .reset       (reset | (wr && adr_i == `RNCS_OFS_BEACON)),
      .sec_tick_ff (sec_tick)
   );

   rncs_chan_sel u_chan (
      .ref_clk     (ref_clk),
      .reset       (reset),
      .chan_map    (REGION_MAP),
      .chan_mask   (mask_ff),
      .active_ff   (act),
      .elig_cnt_ff (elig_cnt),
      .cfg_err_ff  (cfg_err)
   );

   // ----------------------------------------
   // wishbone slave
   // ----------------------------------------
   // one wait state; writes land at the edge that ends the cycle
   assign req = cyc_i & stb_i & ~ack_o;
   assign wr  = cyc_i & stb_i & we_i & ack_o;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  sel;
      integer      k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (sel[k]) begin
               merge[k*8 +: 8] = nw[k*8 +: 8];
            end
         end
      end
   endfunction

   always @* begin
      wval = 32'h00000000;
      case (adr_i)
         `RNCS_OFS_CTRL:     wval = {25'h0000000, ctrl_ff};
         `RNCS_OFS_NODE:     wval = {20'h00000, node_ff};
         `RNCS_OFS_NET:      wval = {17'h00000, net_ff};
         `RNCS_OFS_BEACON:   wval = {16'h0000, beacon_ff};
         `RNCS_OFS_LCHK:     wval = {16'h0000, lchk_ff};
         `RNCS_OFS_HUB:      wval = {20'h00000, hub_ff};
         `RNCS_OFS_MASK_LO:  wval = mask_ff[31:0];
         `RNCS_OFS_MASK_HI:  wval = mask_ff[63:32];
         default:            wval = 32'h00000000;
      endcase
      wval = merge(wval, dat_i, sel_i);
   end

   always @* begin
      nxt_dat = 32'h00000000;
      case (adr_i)
         `RNCS_OFS_CTRL:     nxt_dat = {25'h0000000, ctrl_ff};
         `RNCS_OFS_NODE:     nxt_dat = {20'h00000, node_ff};
         `RNCS_OFS_NET:      nxt_dat = {17'h00000, net_ff};
         `RNCS_OFS_BEACON:   nxt_dat = {16'h0000, beacon_ff};
         `RNCS_OFS_LCHK:     nxt_dat = {16'h0000, lchk_ff};
         `RNCS_OFS_LCHK_EFF: nxt_dat = {14'h0000, lnk_eff};
         `RNCS_OFS_HUB:      nxt_dat = {20'h00000, hub_ff};
         `RNCS_OFS_STAT:     nxt_dat = {16'h0000, 1'b0, elig_cnt,
                                        6'h00, serial_tx_on_ff, cfg_err};
         `RNCS_OFS_RXL:      nxt_dat = {4'h0, rxl_src_ff, 8'h00, rxl_ff};
         `RNCS_OFS_MAP_LO:   nxt_dat = REGION_MAP[31:0];
         `RNCS_OFS_MAP_HI:   nxt_dat = REGION_MAP[63:32];
         `RNCS_OFS_MASK_LO:  nxt_dat = mask_ff[31:0];
         `RNCS_OFS_MASK_HI:  nxt_dat = mask_ff[63:32];
         `RNCS_OFS_ACT_LO:   nxt_dat = act[31:0];
         `RNCS_OFS_ACT_HI:   nxt_dat = act[63:32];
         default: begin
            if (adr_i[7:4] == 4'h4 && adr_i[1:0] == 2'h0) begin
               nxt_dat = nbr_ff[adr_i[3:2]];
            end
         end
      endcase
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_o <= req;
         if (req) begin
            dat_o <= nxt_dat;
         end
      end
   end

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   always @(posedge ref_clk) begin
      if (reset) begin
         ctrl_ff   <= `RNCS_RST_CTRL;
         node_ff   <= `RNCS_RST_NODE;
         net_ff    <= 15'h0000;
         beacon_ff <= 16'h0000;
         lchk_ff   <= 16'h0000;
         hub_ff    <= 12'h000;
         mask_ff   <= `RNCS_RST_MASK;
      end else if (wr) begin
         case (adr_i)
            `RNCS_OFS_CTRL:   ctrl_ff <= wval[6:0];
            `RNCS_OFS_NODE: begin
               // out-of-range values leave the old address in place
               if (wval[31:12] == 20'h00000 &&
                   wval[11:0] >= `RNCS_ADDR_MIN &&
                   wval[11:0] <= `RNCS_ADDR_MAX) begin
                  node_ff <= wval[11:0];
               end
            end
            `RNCS_OFS_NET: begin
               if (wval[31:15] == 17'h00000) begin
                  net_ff <= wval[14:0];
               end
            end
            `RNCS_OFS_BEACON: beacon_ff <= wval[15:0];
            `RNCS_OFS_LCHK:   lchk_ff   <= wval[15:0];
            `RNCS_OFS_HUB:    hub_ff    <= wval[11:0];
            `RNCS_OFS_MASK_LO: mask_ff[31:0]  <= wval;
            `RNCS_OFS_MASK_HI: mask_ff[63:32] <= wval;
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // neighbour range list
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < `RNCS_NBR_CNT; g = g + 1) begin : g_nbr
         always @(posedge ref_clk) begin
            if (reset) begin
               nbr_ff[g] <= 32'h00000000;
            end else if (wr && adr_i == `RNCS_OFS_NBR0 + g * 4) begin
               nbr_ff[g] <= merge(nbr_ff[g], dat_i, sel_i);
            end
         end
         assign nbr_used[g] = nbr_ff[g][`RNCS_NBR_VALID];
         assign nbr_hit[g]  = nbr_used[g] &
                              (cand_addr >= nbr_ff[g][11:0]) &
                              (cand_addr <= nbr_ff[g][27:16]);
      end
   endgenerate

   // filter only bites when acting as a repeater
   assign cand_accept = ~routed | ~(|nbr_used) | (|nbr_hit) |
                        (cand_addr > `RNCS_SW_ADDR_MAX);

   // ----------------------------------------
   // hub hand-off
   // ----------------------------------------
   assign branch_router = (hub_ff >= `RNCS_ADDR_MIN) &&
                          (hub_ff <= `RNCS_ADDR_MAX);
   assign nbr_list_ok   = ~(branch_router & peer_beyond_hub);

   always @(posedge ref_clk) begin
      if (reset) begin
         fwd_to_hub_ff <= 1'b0;
      end else begin
         fwd_to_hub_ff <= no_route & branch_router;
      end
   end

   // ----------------------------------------
   // received level record
   // ----------------------------------------
   always @(posedge ref_clk) begin
      if (reset) begin
         rxl_ff     <= 8'h00;
         rxl_src_ff <= 12'h000;
      end else if (rx_pkt_valid) begin
         rxl_ff     <= rx_signal_level;
         rxl_src_ff <= rx_src_addr;
      end
   end

   // ----------------------------------------
   // beacon and link-check timers
   // ----------------------------------------
   assign routed  = ctrl_ff[`RNCS_CTRL_ROUTED];
   // 2.5x rounds down to whole seconds
   assign lnk_eff = (lchk_ff != 16'h0000) ? {2'h0, lchk_ff} :
                    ({1'b0, beacon_ff, 1'b0} + {3'h0, beacon_ff[15:1]});
   assign hello_link_period = lnk_eff;

   always @(posedge ref_clk) begin
      if (reset) begin
         bcn_cnt_ff       <= 16'h0000;
         beacon_radio_ff  <= 1'b0;
         beacon_serial_ff <= 1'b0;
      end else begin
         beacon_radio_ff  <= 1'b0;
         beacon_serial_ff <= 1'b0;
         if (wr && adr_i == `RNCS_OFS_BEACON) begin
            bcn_cnt_ff <= 16'h0000;
         end else if (beacon_ff == 16'h0000) begin
            bcn_cnt_ff <= 16'h0000;
         end else if (sec_tick) begin
            if (bcn_cnt_ff + 16'h0001 >= beacon_ff) begin
               bcn_cnt_ff       <= 16'h0000;
               beacon_radio_ff  <= routed & ~cfg_err;
               beacon_serial_ff <= ~routed;
            end else begin
               bcn_cnt_ff <= bcn_cnt_ff + 16'h0001;
            end
         end
      end
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         lnk_cnt_ff      <= 18'h00000;
         hello_radio_ff  <= 1'b0;
         hello_serial_ff <= 1'b0;
      end else begin
         hello_radio_ff  <= 1'b0;
         hello_serial_ff <= 1'b0;
         if (nbr_traffic || lnk_eff == 18'h00000) begin
            lnk_cnt_ff <= 18'h00000;
         end else if (sec_tick) begin
            if (lnk_cnt_ff + 18'h00001 >= lnk_eff) begin
               lnk_cnt_ff      <= 18'h00000;
               hello_radio_ff  <= routed & ~cfg_err;
               hello_serial_ff <= ~routed;
            end else begin
               lnk_cnt_ff <= lnk_cnt_ff + 18'h00001;
            end
         end
      end
   end

   // ----------------------------------------
   // serial port
   // ----------------------------------------
   always @(posedge ref_clk) begin
      if (reset) begin
         idle_cnt_ff     <= 5'h00;
         serial_tx_on_ff <= 1'b1;
      end else if (serial_activity || !ctrl_ff[`RNCS_CTRL_IDLE_SD]) begin
         idle_cnt_ff     <= 5'h00;
         serial_tx_on_ff <= 1'b1;
      end else if (sec_tick) begin
         if (idle_cnt_ff + 5'h01 >= `RNCS_IDLE_SEC) begin
            serial_tx_on_ff <= 1'b0;
         end else begin
            idle_cnt_ff <= idle_cnt_ff + 5'h01;
         end
      end
   end

   assign serial_parity   = ctrl_ff[`RNCS_CTRL_PAR_LO +: 2];
   assign serial_two_stop = ctrl_ff[`RNCS_CTRL_STOP];
   assign serial_char_len = ctrl_ff[`RNCS_CTRL_LEN_LO +: 2];

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign node_address   = node_ff;
   assign network_number = net_ff;
   assign hub_address    = hub_ff;
   assign active_chan    = act;
   assign tx_enable      = ~cfg_err;

endmodule

// ---- tb/rncs_top_monitor.sv ----
// assertion checker for rncs_top, bound at its ports
// assumes: one clock ref_clk, synchronous active-high reset
`timescale 1ns/1ps
module rncs_top_monitor #(
   parameter SEC_CYCLES = 20
) (
   input logic        ref_clk,
   input logic        reset,
   input logic        cyc_i,
   input logic        stb_i,
   input logic        ack_o,
   input logic [31:0] dat_o,
   input logic        no_route,
   input logic        peer_beyond_hub,
   input logic [11:0] cand_addr,
   input logic        serial_activity,
   input logic        cand_accept,
   input logic        nbr_list_ok,
   input logic        fwd_to_hub_ff,
   input logic        beacon_radio_ff,
   input logic        beacon_serial_ff,
   input logic        hello_radio_ff,
   input logic        hello_serial_ff,
   input logic [11:0] node_address,
   input logic [11:0] hub_address,
   input logic        branch_router,
   input logic [63:0] active_chan,
   input logic        tx_enable,
   input logic        serial_tx_on_ff
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered in one cycle");
   a_dat_hold: assert property (!cyc_i |=> $stable(dat_o))
      else $error("read data moved without a request");
   a_node_range: assert property (node_address != 12'h000 && node_address != 12'hfff)
      else $error("node address out of range");
   a_hub_forward: assert property (fwd_to_hub_ff == $past(no_route && branch_router))
      else $error("hub hand-off wrong");
   a_branch_range: assert property (branch_router ==
      (hub_address != 12'h000 && hub_address != 12'hfff))
      else $error("branch mode does not follow hub address");
   a_list_block: assert property (peer_beyond_hub && branch_router |-> !nbr_list_ok)
      else $error("list exchange beyond hub");
   a_high_accept: assert property (cand_addr > 12'd3999 |-> cand_accept)
      else $error("high candidate rejected");
   a_active_count: assert property (tx_enable |-> $countones(active_chan) == 25)
      else $error("active set not 25 channels");
   a_radio_quiet: assert property (!tx_enable && !$past(tx_enable) |->
      !beacon_radio_ff && !hello_radio_ff)
      else $error("radio traffic with too few channels");
   a_beacon_route: assert property (!(beacon_radio_ff && beacon_serial_ff))
      else $error("beacon on both routes");
   a_idle_off: assert property ($fell(serial_tx_on_ff) |-> !$past(serial_activity))
      else $error("serial driver off right after activity");
   c_beacon: cover property (beacon_serial_ff);
   c_hello: cover property (hello_serial_ff);
   c_forward: cover property (fwd_to_hub_ff);
   c_idle: cover property ($fell(serial_tx_on_ff));
endmodule

bind rncs_top rncs_top_monitor #(.SEC_CYCLES(SEC_CYCLES)) rncs_top_monitor_inst (
   .ref_clk, .reset, .cyc_i, .stb_i, .ack_o, .dat_o, .no_route, .peer_beyond_hub,
   .cand_addr, .serial_activity, .cand_accept, .nbr_list_ok, .fwd_to_hub_ff,
   .beacon_radio_ff, .beacon_serial_ff, .hello_radio_ff, .hello_serial_ff,
   .node_address, .hub_address, .branch_router, .active_chan, .tx_enable,
   .serial_tx_on_ff);

// ---- tb/rncs_peer_model.sv ----
// peer radios and serial loggers as seen by the node
// assumes: send_* requests come from the bench on ref_clk
`timescale 1ns/1ps
module rncs_peer_model (
   input  wire         ref_clk,
   input  wire         reset,
   input  wire         send_pkt,
   input  wire         send_nbr,
   input  wire         send_ser,
   input  wire [7:0]   pkt_lvl,
   input  wire [11:0]  pkt_src,
   output logic        rx_pkt_valid,
   output logic [7:0]  rx_signal_level,
   output logic [11:0] rx_src_addr,
   output logic        nbr_traffic,
   output logic        serial_activity
);
   always @(posedge ref_clk) begin
      rx_pkt_valid <= send_pkt & ~reset;
      nbr_traffic <= send_nbr & ~reset;
      serial_activity <= send_ser & ~reset;
      // level and source mean nothing without valid, so keep them moving
      if (reset) begin
         rx_signal_level <= 8'h00;
         rx_src_addr <= 12'h000;
      end else if (send_pkt) begin
         rx_signal_level <= pkt_lvl;
         rx_src_addr <= pkt_src;
      end else begin
         rx_signal_level <= ~rx_signal_level;
         rx_src_addr <= ~rx_src_addr;
      end
   end
endmodule

// ---- tb/rncs_top_tb_top.sv ----
// bench for rncs_top: registers, timers, filter, channel set
// assumes: second shortened to 20 cycles, all-ones region map
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
$display("[FAIL] %s exp %h got %h", nm, e, g); end end

module rncs_top_tb_top;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} rncs_row_t;
   logic ref_clk = 0, reset = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic no_route = 0, peer_beyond_hub = 0, send_pkt = 0, send_nbr = 0, send_ser = 0;
   logic [7:0] adr_i = 0, pkt_lvl = 0;
   logic [3:0] sel_i = 4'hf;
   logic [31:0] dat_i = 0, q;
   logic [11:0] cand_addr = 0, pkt_src = 0;
   wire [31:0] dat_o;
   wire [63:0] active_chan;
   wire [17:0] hello_link_period;
   wire [14:0] network_number;
   wire [11:0] node_address, hub_address, rx_src_addr;
   wire [7:0] rx_signal_level;
   wire [1:0] serial_parity, serial_char_len;
   wire ack_o, cand_accept, nbr_list_ok, fwd_to_hub_ff, beacon_radio_ff, beacon_serial_ff;
   wire hello_radio_ff, hello_serial_ff, branch_router, tx_enable, serial_tx_on_ff;
   wire serial_two_stop, rx_pkt_valid, nbr_traffic, serial_activity;
   int errors = 0, compares = 0, n, k;
   rncs_row_t rows [13] = '{'{8'h34, 0, 32'h03f7ffff}, '{8'h1c, 0, 32'h3f02},
      '{8'h24, 0, 32'hffffffff}, '{8'h04, 5, 5}, '{8'h04, 0, 5}, '{8'h04, 32'hffe, 32'hffe},
      '{8'h04, 32'hfff, 32'hffe}, '{8'h08, 32'h7fff, 32'h7fff}, '{8'h08, 32'h8000, 32'h7fff},
      '{8'h3c, 32'h1234, 0}, '{8'h2c, 32'hffffffff, 32'hffffffff},
      '{8'h34, 0, 32'h01ffffff}, '{8'h00, 32'h7c, 32'h7c}};
   logic [12:0] cands [6] = '{{1'b1, 12'd15}, {1'b0, 12'd21}, {1'b0, 12'd9},
      {1'b1, 12'd10}, {1'b1, 12'd20}, {1'b1, 12'd4000}};

   rncs_top #(.SEC_CYCLES(20)) rncs_top_inst (.ref_clk, .reset, .cyc_i, .stb_i, .we_i,
      .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .rx_pkt_valid, .rx_signal_level, .rx_src_addr,
      .nbr_traffic, .no_route, .peer_beyond_hub, .cand_addr, .serial_activity, .cand_accept,
      .nbr_list_ok, .fwd_to_hub_ff, .beacon_radio_ff, .beacon_serial_ff, .hello_radio_ff,
      .hello_serial_ff, .hello_link_period, .node_address, .network_number, .hub_address,
      .branch_router, .active_chan, .tx_enable, .serial_tx_on_ff, .serial_parity,
      .serial_two_stop, .serial_char_len);
   rncs_peer_model rncs_peer_model_inst (.ref_clk, .reset, .send_pkt, .send_nbr,
      .send_ser, .pkt_lvl, .pkt_src, .rx_pkt_valid, .rx_signal_level, .rx_src_addr,
      .nbr_traffic, .serial_activity);

   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic end_sim;
      begin
         $display("compares %0d errors %0d", compares, errors);
         if (errors == 0 && compares > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask

   // classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      begin
         t = 0;
         cyc_i <= 1;
         stb_i <= 1;
         we_i <= w;
         adr_i <= a;
         dat_i <= d;
         do begin
            @(posedge ref_clk);
            t++;
         end while (ack_o !== 1'b1 && t < 50);
         if (t >= 50) begin
            errors++;
            end_sim();
         end
         q = dat_o;
         cyc_i <= 0;
         stb_i <= 0;
         @(posedge ref_clk);
      end
   endtask

   function automatic logic ev(input int s);
      case (s)
         0: ev = beacon_serial_ff;
         1: ev = beacon_radio_ff;
         2: ev = hello_serial_ff;
         default: ev = ~serial_tx_on_ff;
      endcase
   endfunction

   task automatic wait_ev(input int s, input int lim);
      begin
         n = 0;
         do begin
            @(posedge ref_clk);
            n++;
         end while (ev(s) !== 1'b1 && n < lim);
         if (n >= lim) begin
            errors++;
            end_sim();
         end
      end
   endtask

   initial begin
      repeat (12) @(posedge ref_clk);
      reset <= 0;
      repeat (2) @(posedge ref_clk);
      foreach (rows[i]) begin
         wb(1, rows[i].a, rows[i].d);
         wb(0, rows[i].a, 0);
         `CHK("register", rows[i].e, q)
      end
      `CHK("framing", 5'h1f, {serial_char_len, serial_two_stop, serial_parity})
      `CHK("network", 15'h7fff, network_number)
      $display("done table");
      reset <= 1;
      repeat (2) @(posedge ref_clk);
      reset <= 0;
      @(posedge ref_clk);
      wb(0, 8'h04, 0);
      `CHK("node after reset", 32'h1, q)
      wb(0, 8'h2c, 0);
      `CHK("mask after reset", 32'hfff7ffff, q)
      $display("done reset");
      wb(1, 8'h0c, 3);
      wait_ev(0, 100);
      `CHK("first beacon", 1'b1, n >= 60 && n <= 62)
      wait_ev(0, 100);
      `CHK("beacon gap", 60, n)
      wb(1, 8'h00, 1);
      wait_ev(1, 100);
      `CHK("radio beacon", 1'b1, n <= 60)
      wb(1, 8'h0c, 0);
      k = 0;
      repeat (200) begin
         @(posedge ref_clk);
         k += beacon_radio_ff | beacon_serial_ff;
      end
      `CHK("beacons off", 0, k)
      $display("done beacon");
      wb(1, 8'h0c, 3);
      wb(1, 8'h10, 0);
      `CHK("derived period", 17'd7, hello_link_period)
      wb(0, 8'h14, 0);
      `CHK("reported period", 32'h7, q)
      wb(1, 8'h10, 2);
      `CHK("hello period", 17'd2, hello_link_period)
      wb(1, 8'h0c, 0);
      wb(1, 8'h00, 0);
      send_nbr <= 1;
      repeat (50) @(posedge ref_clk);
      send_nbr <= 0;
      wait_ev(2, 100);
      `CHK("hello", 1'b1, n >= 19 && n <= 44)
      $display("done hello");
      wb(1, 8'h18, 32'h123);
      no_route <= 1;
      peer_beyond_hub <= 1;
      @(posedge ref_clk);
      no_route <= 0;
      @(posedge ref_clk);
      `CHK("forward", 1'b1, fwd_to_hub_ff)
      `CHK("list block", 1'b0, nbr_list_ok)
      wb(1, 8'h18, 32'hfff);
      `CHK("no branch", 1'b0, branch_router)
      wb(1, 8'h00, 1);
      cand_addr <= 12'd21;
      @(posedge ref_clk);
      `CHK("empty list", 1'b1, cand_accept)
      wb(1, 8'h40, 32'h8014000a);
      foreach (cands[i]) begin
         cand_addr <= cands[i][11:0];
         @(posedge ref_clk);
         `CHK("filter", cands[i][12], cand_accept)
      end
      $display("done routing");
      pkt_lvl <= 8'h46;
      pkt_src <= 12'h0c9;
      send_pkt <= 1;
      @(posedge ref_clk);
      send_pkt <= 0;
      repeat (2) @(posedge ref_clk);
      wb(0, 8'h20, 0);
      `CHK("signal record", 32'h00c90046, q)
      wb(1, 8'h2c, 32'h00ffffff);
      wb(1, 8'h30, 0);
      wb(0, 8'h1c, 0);
      `CHK("status", 32'h1803, q)
      `CHK("tx blocked", 1'b0, tx_enable)
      $display("done channels");
      `CHK("driver on", 1'b1, serial_tx_on_ff)
      wb(1, 8'h00, 2);
      send_ser <= 1;
      @(posedge ref_clk);
      send_ser <= 0;
      wait_ev(3, 700);
      `CHK("idle off", 1'b1, n >= 575 && n <= 625)
      $display("done idle");
      end_sim();
   end
endmodule
